// [design/sfrl_logger.sv]
// Purpose: Fault reactions per supply, retry timing, fault output, status and
//          nonvolatile fault record storage with block readback.
// Assumes: Fault pins are asynchronous; measurements and commands share i_sys_clk.
// Notes:   Sequencing steps are one per millisecond tick, lowest supply first; i_off_at_once turns off all pending supplies in one tick.
module sfrl_logger #(
	parameter int unsigned MS_CYCLES = sfrl_pkg::MS_TIME_NS / sfrl_pkg::CLK_PERIOD_NS
) (
	// Clock and reset
	input  wire logic                         i_sys_clk,
	input  wire logic                         i_rst,
	// Fault pins and enables
	input  wire sfrl_pkg::sfrl_faults_s       i_faults,
	input  wire logic [sfrl_pkg::NTEMP-1:0]   i_temp_en,
	input  wire logic [sfrl_pkg::NSUP-1:0]    i_supply_on,
	input  wire logic                         i_off_at_once,
	input  wire logic                         i_user_restart,
	// Measurements
	input  wire logic [sfrl_pkg::NSUP*16-1:0] i_vout,
	input  wire logic [sfrl_pkg::NSUP*16-1:0] i_iout,
	input  wire logic [sfrl_pkg::NSUP-1:0]    i_meas_en,
	input  wire logic                         i_nv_err,
	// Command port
	input  wire sfrl_pkg::sfrl_cmd_s          i_cmd,
	input  wire logic                         i_log_rd,
	output logic [15:0]                       o_cmd_rdata,
	output logic [7:0]                        o_log_byte,
	output logic                              o_log_valid,
	// Supply and alert outputs
	output logic [sfrl_pkg::NSUP-1:0]         o_supply_enable_out,
	output logic                              o_fault,
	output logic                              o_alert
);
	localparam int NS = sfrl_pkg::NSUP;
	localparam int NF = 6;
	localparam int SAMPLE_CYC = sfrl_pkg::SAMPLE_MS;

	logic [15:0] cfg_r [NS];
	logic [15:0] retry_r, mode_r;
	sfrl_pkg::sfrl_faults_s s1_r, s2_r, prev_r;
	logic [NS*NF-1:0] stat_r, ev, flt_lvl;
	logic        cml_r, full_r, alert_r, log_req;
	logic [31:0] ms_cnt_r;
	logic [7:0]  tick_cnt_r;
	logic        ms_tick, tick100_r, cur_phase_r;

	function automatic logic [1:0] sev(input logic [1:0] code);
		case (code)
			2'b11:   sev = 2'd1;
			2'b10:   sev = 2'd2;
			2'b01:   sev = 2'd3;
			default: sev = 2'd0;
		endcase
	endfunction

	// Command writes.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			for (int s = 0; s < NS; s++) cfg_r[s] <= sfrl_pkg::CFG_RESET;
			retry_r <= sfrl_pkg::RETRY_RESET;
			mode_r <= sfrl_pkg::MODE_RESET;
		end else if (i_cmd.wr) begin
			if (i_cmd.code == sfrl_pkg::CMD_FAULT_RESPONSE && i_cmd.page < 3'(NS)) begin
				cfg_r[i_cmd.page] <= i_cmd.data & sfrl_pkg::CFG_WMASK;
			end else if (i_cmd.code == sfrl_pkg::CMD_FAULT_RETRY) begin
				retry_r <= i_cmd.data;
			end else if (i_cmd.code == sfrl_pkg::CMD_MODE) begin
				mode_r <= i_cmd.data;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_cmd_rdata <= 16'h0000;
		end else if (i_cmd.rd) begin
			if (i_cmd.code == sfrl_pkg::CMD_FAULT_RESPONSE && i_cmd.page < 3'(NS)) begin
				o_cmd_rdata <= cfg_r[i_cmd.page];
			end else if (i_cmd.code == sfrl_pkg::CMD_FAULT_RETRY) begin
				o_cmd_rdata <= retry_r;
			end else if (i_cmd.code == sfrl_pkg::CMD_MODE) begin
				o_cmd_rdata <= mode_r;
			end else if (i_cmd.code == sfrl_pkg::CMD_STATUS) begin
				o_cmd_rdata <= {cml_r, full_r, o_fault, 13'(|stat_r)};
			end else begin
				o_cmd_rdata <= 16'h0000;
			end
		end
	end

	// Pins are asynchronous, so two flops before any use.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			s1_r <= '0;
			s2_r <= '0;
			prev_r <= '0;
		end else begin
			s1_r <= i_faults;
			s2_r <= s1_r;
			prev_r <= s2_r;
		end
	end

	// Millisecond tick and 100 ms sampling tick.
	assign ms_tick = (ms_cnt_r == MS_CYCLES - 1);
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || ms_tick) ms_cnt_r <= 32'h0;
		else ms_cnt_r <= ms_cnt_r + 32'h1;
	end
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			tick_cnt_r <= 8'h00;
			tick100_r <= 1'b0;
			cur_phase_r <= 1'b0;
		end else begin
			tick100_r <= ms_tick && tick_cnt_r == 8'(SAMPLE_CYC - 1);
			if (tick100_r) cur_phase_r <= ~cur_phase_r;
			if (ms_tick) tick_cnt_r <= (tick_cnt_r == 8'(SAMPLE_CYC - 1)) ? 8'h00 : tick_cnt_r + 8'h01;
		end
	end

	// Per-supply severity decision.
	logic [1:0] sev_s [NS];
	logic [1:0] glob_sev;
	logic       ot_lvl, ot_ev, fan_ev;
	always_comb begin
		ot_lvl = |(s2_r.temp & i_temp_en);
		ot_ev = ot_lvl && !(|(prev_r.temp & i_temp_en));
		fan_ev = s2_r.fan && !prev_r.fan;
		glob_sev = 2'd0;
		log_req = 1'b0;
		for (int s = 0; s < NS; s++) begin
			flt_lvl[s*NF+0] = s2_r.ov[s];
			flt_lvl[s*NF+1] = s2_r.uv[s];
			flt_lvl[s*NF+2] = s2_r.ton[s];
			flt_lvl[s*NF+3] = ot_lvl && i_supply_on[s];
			flt_lvl[s*NF+4] = s2_r.oc[s];
			flt_lvl[s*NF+5] = s2_r.fan && i_supply_on[s];
			ev[s*NF+0] = s2_r.ov[s] && !prev_r.ov[s];
			ev[s*NF+1] = s2_r.uv[s] && !prev_r.uv[s];
			ev[s*NF+2] = s2_r.ton[s] && !prev_r.ton[s];
			// system faults reach every enabled supply
			ev[s*NF+3] = ot_ev && i_supply_on[s];
			ev[s*NF+4] = s2_r.oc[s] && !prev_r.oc[s];
			ev[s*NF+5] = fan_ev && i_supply_on[s];
			sev_s[s] = 2'd0;
			for (int f = 0; f < NF; f++) begin
				if (ev[s*NF+f]) begin
					if (sev(cfg_r[s][2*f+:2]) > sev_s[s]) sev_s[s] = sev(cfg_r[s][2*f+:2]);
					if (cfg_r[s][sfrl_pkg::BIT_LOG] && sev(cfg_r[s][2*f+:2]) != 2'd0) log_req = 1'b1;
				end
			end
			// global members pool their worst response
			if (cfg_r[s][sfrl_pkg::BIT_GLOBAL] && sev_s[s] > glob_sev) glob_sev = sev_s[s];
		end
		for (int s = 0; s < NS; s++) begin
			if (cfg_r[s][sfrl_pkg::BIT_GLOBAL] && i_supply_on[s]) sev_s[s] = glob_sev;
		end
	end

	// Status latch and alert; new setting beats a clear in the same cycle.
	logic clr_faults;
	assign clr_faults = i_cmd.wr && i_cmd.code == sfrl_pkg::CMD_CLEAR_FAULTS;
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			stat_r <= '0;
			alert_r <= 1'b0;
		end else begin
			// latch first occurrence, alert on new bits
			stat_r <= (clr_faults ? '0 : stat_r) | ev;
			if ((|(ev & ~stat_r) || (i_nv_err && !cml_r)) && mode_r[sfrl_pkg::BIT_ALERT_EN]) begin
				alert_r <= 1'b1;
			end else if (clr_faults) begin
				alert_r <= 1'b0;
			end
		end
	end

	// Shutdown, latch-off and restart sequencing.
	logic [NS-1:0] off_r, latch_r, pend_off_r, pend_on_r, glob_m, off_pick, on_pick;
	logic [15:0]   retry_cnt_r;
	logic          retry_wait_r, retry_run_r, expire, glob_retry_r, glob_latch_r, retry_any;
	always_comb begin
		for (int s = 0; s < NS; s++) glob_m[s] = cfg_r[s][sfrl_pkg::BIT_GLOBAL];
		off_pick = i_off_at_once ? pend_off_r : (pend_off_r & (~pend_off_r + 5'd1));
		on_pick = pend_on_r & (~pend_on_r + 5'd1);
		expire = retry_run_r && ms_tick && retry_cnt_r == 16'h0000;
		retry_any = 1'b0;
		for (int s = 0; s < NS; s++) if (sev_s[s] == 2'd2) retry_any = 1'b1;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			off_r <= '0;
			latch_r <= '0;
			pend_off_r <= '0;
			pend_on_r <= '0;
		end else begin
			for (int s = 0; s < NS; s++) begin
				// disable on retry or latch codes
				if (sev_s[s] >= 2'd2 && i_supply_on[s] && !off_r[s]) pend_off_r[s] <= 1'b1;
				else if (ms_tick && off_pick[s]) pend_off_r[s] <= 1'b0;
				if (ms_tick && off_pick[s]) off_r[s] <= 1'b1;
				else if (ms_tick && on_pick[s]) off_r[s] <= 1'b0;
				if (sev_s[s] == 2'd3) latch_r[s] <= 1'b1;
				else if (i_user_restart) latch_r[s] <= 1'b0;
				if (expire && off_r[s] && !latch_r[s]) pend_on_r[s] <= 1'b1;
				else if (i_user_restart && latch_r[s]) pend_on_r[s] <= 1'b1;
				else if (ms_tick && on_pick[s]) pend_on_r[s] <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			retry_wait_r <= 1'b0;
			retry_run_r <= 1'b0;
			retry_cnt_r <= 16'h0000;
		end else begin
			if (retry_any) retry_wait_r <= 1'b1;
			// wait for every pending shutdown first
			else if (retry_wait_r && pend_off_r == '0) retry_wait_r <= 1'b0;
			if (retry_wait_r && pend_off_r == '0) begin
				retry_run_r <= 1'b1;
				// count whole ms ticks, zero ends next tick
				retry_cnt_r <= retry_r;
			end else if (expire) begin
				retry_run_r <= 1'b0;
			end else if (retry_run_r && ms_tick) begin
				retry_cnt_r <= retry_cnt_r - 16'h0001;
			end
		end
	end

	logic glob_flt;
	always_comb begin
		glob_flt = 1'b0;
		for (int s = 0; s < NS; s++) begin
			if (glob_m[s] && (|flt_lvl[s*NF+:NF])) glob_flt = 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			glob_retry_r <= 1'b0;
			glob_latch_r <= 1'b0;
			o_fault <= 1'b0;
			o_supply_enable_out <= '0;
			o_alert <= 1'b0;
		end else begin
			// held until global faults clear and the delay ends
			if (glob_sev == 2'd2) glob_retry_r <= 1'b1;
			else if (!glob_flt && !retry_wait_r && !retry_run_r) glob_retry_r <= 1'b0;
			if (glob_sev == 2'd3) glob_latch_r <= 1'b1;
			else if (i_user_restart) glob_latch_r <= 1'b0;
			o_fault <= glob_retry_r | glob_latch_r;
			o_supply_enable_out <= i_supply_on & ~off_r;
			o_alert <= alert_r;
		end
	end

	// Measurement history, a voltage and a current shift register per supply.
	logic [15:0] vh_r [NS][sfrl_pkg::VHIST];
	logic [15:0] ih_r [NS][sfrl_pkg::IHIST];
	for (genvar s = 0; s < NS; s++) begin : g_hist
		always_ff @(posedge i_sys_clk) begin
			if (i_rst) begin
				for (int k = 0; k < sfrl_pkg::VHIST; k++) vh_r[s][k] <= 16'h0000;
				for (int k = 0; k < sfrl_pkg::IHIST; k++) ih_r[s][k] <= 16'h0000;
			end else if (tick100_r) begin
				// 100 ms voltages, 200 ms currents, zero if off
				vh_r[s][0] <= i_meas_en[s] ? i_vout[s*16+:16] : 16'h0000;
				for (int k = 1; k < sfrl_pkg::VHIST; k++) vh_r[s][k] <= vh_r[s][k-1];
				if (cur_phase_r) begin
					ih_r[s][0] <= i_meas_en[s] ? i_iout[s*16+:16] : 16'h0000;
					for (int k = 1; k < sfrl_pkg::IHIST; k++) ih_r[s][k] <= ih_r[s][k-1];
				end
			end
		end
	end

	// Record writer and storage.
	typedef enum logic {W_IDLE, W_BUSY} sfrl_wst_e;
	sfrl_wst_e   wst_r;
	logic [15:0] log_mem [sfrl_pkg::NSLOT * sfrl_pkg::SLOT_WORDS];
	logic [sfrl_pkg::NSLOT-1:0] valid_r;
	logic [3:0]  wr_slot_r, rd_slot_r;
	logic [6:0]  widx_r;
	logic [15:0] count_r, wdata;
	logic        clr_log;
	assign clr_log = i_cmd.wr && i_cmd.code == sfrl_pkg::CMD_MODE && i_cmd.data[sfrl_pkg::BIT_CLEAR_LOG];

	always_comb begin
		wdata = 16'h0000;
		if (widx_r == 7'(sfrl_pkg::W_COUNT)) wdata = count_r;
		else if (widx_r == 7'(sfrl_pkg::W_STAT_LO)) wdata = stat_r[15:0];
		else if (widx_r == 7'(sfrl_pkg::W_STAT_HI)) wdata = 16'(stat_r[NS*NF-1:16]);
		else if (widx_r == 7'(sfrl_pkg::W_CML)) wdata = {15'h0000, cml_r};
		for (int s = 0; s < NS; s++) begin
			for (int k = 0; k < sfrl_pkg::VHIST; k++)
				if (widx_r == 7'(sfrl_pkg::W_VOLT + s*sfrl_pkg::VHIST + k)) wdata = vh_r[s][k];
			for (int k = 0; k < sfrl_pkg::IHIST; k++)
				if (widx_r == 7'(sfrl_pkg::W_CURR + s*sfrl_pkg::IHIST + k)) wdata = ih_r[s][k];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			wst_r <= W_IDLE;
			wr_slot_r <= 4'h0;
			widx_r <= 7'h00;
			count_r <= 16'h0000;
			valid_r <= '0;
			full_r <= 1'b0;
			cml_r <= 1'b0;
		end else begin
			if (i_nv_err) cml_r <= 1'b1;
			else if (clr_faults) cml_r <= 1'b0;
			case (wst_r)
				W_IDLE: begin
					if (clr_log) begin
						valid_r <= '0;
						wr_slot_r <= 4'h0;
						full_r <= 1'b0;
					end else if (log_req && full_r) begin
						full_r <= 1'b1;
					end else if (log_req) begin
						count_r <= count_r + 16'h0001;
						widx_r <= 7'h00;
						wst_r <= W_BUSY;
					end
				end
				W_BUSY: begin
					// A slot is exactly 128 words, so slot and word concatenate.
					log_mem[{wr_slot_r, widx_r}] <= wdata;
					widx_r <= widx_r + 7'h01;
					if (widx_r == 7'(sfrl_pkg::SLOT_WORDS - 1)) begin
						valid_r[wr_slot_r] <= 1'b1;
						wst_r <= W_IDLE;
						if (wr_slot_r == 4'(sfrl_pkg::NSLOT - 1)) full_r <= 1'b1;
						else wr_slot_r <= wr_slot_r + 4'h1;
					end
				end
				default: wst_r <= W_IDLE;
			endcase
		end
	end

	// Record readback: two stage pipe, one byte per cycle.
	logic [7:0]  rbyte_r;
	logic        ract_r, rvalid_slot_r, rv1_r, rhi_r;
	logic [15:0] rword_r;
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			ract_r <= 1'b0;
			rbyte_r <= 8'h00;
			rd_slot_r <= 4'h0;
			rvalid_slot_r <= 1'b0;
		end else if (!ract_r && i_log_rd) begin
			ract_r <= 1'b1;
			rbyte_r <= 8'h00;
			rvalid_slot_r <= valid_r[rd_slot_r];
		end else if (ract_r) begin
			rbyte_r <= rbyte_r + 8'h01;
			// 255 bytes then step to the next slot
			if (rbyte_r == 8'(sfrl_pkg::LOG_BYTES - 1)) begin
				ract_r <= 1'b0;
				rd_slot_r <= (rd_slot_r == 4'(sfrl_pkg::NSLOT - 1)) ? 4'h0 : rd_slot_r + 4'h1;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			rv1_r <= 1'b0;
			rhi_r <= 1'b0;
			rword_r <= 16'h0000;
			o_log_valid <= 1'b0;
			o_log_byte <= 8'h00;
		end else begin
			rv1_r <= ract_r;
			rhi_r <= rbyte_r[0];
			// unwritten slots read as all FF
			rword_r <= rvalid_slot_r ? log_mem[{rd_slot_r, rbyte_r[7:1]}] : sfrl_pkg::EMPTY_WORD;
			o_log_valid <= rv1_r;
			o_log_byte <= rhi_r ? rword_r[15:8] : rword_r[7:0];
		end
	end
endmodule // sfrl_logger

// [design/sfrl_pkg.sv]
// Purpose: Shared constants and types for the supply fault response logger.
// Assumes: Five supplies, six temperature sensors, one fan, 200 MHz clock.
// Notes:   Command codes double as register offsets on the command port.
package sfrl_pkg;
	localparam int NSUP = 5;
	localparam int NTEMP = 6;
	localparam int NSLOT = 15;
	localparam int SLOT_WORDS = 128;
	localparam int LOG_BYTES = 255;
	localparam int VHIST = 8;
	localparam int IHIST = 4;
	localparam int CLK_PERIOD_NS = 5;
	localparam int MS_TIME_NS = 1000000;
	localparam int SAMPLE_MS = 100;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_STATUS = 8'h79;
	localparam logic [7:0] CMD_MODE = 8'hD1;
	localparam logic [7:0] CMD_FAULT_RESPONSE = 8'hD9;
	localparam logic [7:0] CMD_FAULT_RETRY = 8'hDA;
	localparam int BIT_LOG = 15;
	localparam int BIT_GLOBAL = 14;
	localparam int BIT_ALERT_EN = 0;
	localparam int BIT_CLEAR_LOG = 11;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [15:0] RETRY_RESET = 16'h0000;
	localparam logic [15:0] MODE_RESET = 16'h0001;
	localparam logic [15:0] CFG_WMASK = 16'hCFFF;
	localparam logic [15:0] EMPTY_WORD = 16'hFFFF;
	localparam int W_COUNT = 0;
	localparam int W_STAT_LO = 1;
	localparam int W_STAT_HI = 2;
	localparam int W_CML = 3;
	localparam int W_VOLT = 8;
	localparam int W_CURR = 48;
	typedef enum logic [1:0] {RSP_IGNORE, RSP_LATCH, RSP_RETRY, RSP_LOG} sfrl_rsp_e;
	typedef struct packed {
		logic [4:0] ov;
		logic [4:0] uv;
		logic [4:0] ton;
		logic [4:0] oc;
		logic [5:0] temp;
		logic       fan;
	} sfrl_faults_s;
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  code;
		logic [2:0]  page;
		logic [15:0] data;
	} sfrl_cmd_s;
endpackage

// [tb/sfrl_logger_checker.sv]
// Purpose: Concurrent checks on the ports of the supply fault response logger.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   Latencies follow the designer's registered-output hand-over figures.
module sfrl_logger_checker #(
	parameter int unsigned MS_CYCLES = 20
) (
	// Clock and reset
	input  wire logic                      i_sys_clk,
	input  wire logic                      i_rst,
	// Watched inputs
	input  wire sfrl_pkg::sfrl_faults_s    i_faults,
	input  wire logic                      i_user_restart,
	input  wire logic                      i_nv_err,
	input  wire sfrl_pkg::sfrl_cmd_s       i_cmd,
	input  wire logic                      i_log_rd,
	// Watched outputs
	input  wire logic [15:0]               o_cmd_rdata,
	input  wire logic                      o_log_valid,
	input  wire logic [sfrl_pkg::NSUP-1:0] o_supply_enable_out,
	input  wire logic                      o_fault,
	input  wire logic                      o_alert
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] run_r;
	logic [7:0] quiet_r;

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	sequence retry_set;
		i_cmd.wr && i_cmd.code == sfrl_pkg::CMD_FAULT_RETRY;
	endsequence
	sequence retry_get;
		i_cmd.rd && i_cmd.code == sfrl_pkg::CMD_FAULT_RETRY;
	endsequence

	always_ff @(posedge i_sys_clk) begin
		if (i_rst || !o_log_valid) begin
			run_r <= 9'h000;
		end else begin
			run_r <= run_r + 9'h001;
		end
	end

	// An alert with no recent cause points at a status bit set from nowhere.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			quiet_r <= 8'hFF;
		end else if (i_faults != '0 || i_nv_err || i_cmd.wr) begin
			quiet_r <= 8'h00;
		end else if (quiet_r != 8'hFF) begin
			quiet_r <= quiet_r + 8'h01;
		end
	end

	reset_quiet_a: assert property (disable iff (1'b0)
		i_rst |=> o_supply_enable_out == '0 && !o_fault && !o_alert && !o_log_valid)
		else $error("outputs active after reset");
	stream_len_a: assert property (!o_log_valid && run_r != 9'h000 |-> run_r == 9'h0FF)
		else $error("record stream length wrong");
	stream_start_a: assert property ($rose(o_log_valid) |-> $past(i_log_rd, 3))
		else $error("record stream without request");
	answer_hold_a: assert property (!i_cmd.rd |=> $stable(o_cmd_rdata))
		else $error("read answer changed without read");
	reserved_zero_a: assert property (
		i_cmd.rd && i_cmd.code == sfrl_pkg::CMD_FAULT_RESPONSE |=> o_cmd_rdata[13:12] == 2'h0)
		else $error("reserved response bits nonzero");
	retry_readback_a: assert property (
		retry_set ##1 !i_cmd.wr ##1 retry_get |=> o_cmd_rdata == $past(i_cmd.data, 3))
		else $error("retry delay readback wrong");
	alert_cause_a: assert property ($rose(o_alert) |-> quiet_r < 8'h10)
		else $error("alert without new status");
	alert_hold_a: assert property ($fell(o_alert) |-> $past(i_cmd.wr) || $past(i_cmd.wr, 2))
		else $error("alert dropped without command");
	restart_clear_a: assert property (
		i_user_restart && i_faults == '0 |-> ##[1:3] !o_fault)
		else $error("fault output kept after user restart");
endmodule // sfrl_logger_checker

bind sfrl_logger sfrl_logger_checker #(.MS_CYCLES(MS_CYCLES)) i_sfrl_logger_checker (
	.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_faults(i_faults),
	.i_user_restart(i_user_restart), .i_nv_err(i_nv_err), .i_cmd(i_cmd),
	.i_log_rd(i_log_rd), .o_cmd_rdata(o_cmd_rdata), .o_log_valid(o_log_valid),
	.o_supply_enable_out(o_supply_enable_out), .o_fault(o_fault), .o_alert(o_alert)
);

// [tb/sfrl_host.sv]
// Purpose: Host on the command port; issues commands and fault record reads.
// Assumes: Requests change on the falling edge, one request at a time.
// Notes:   The last record read stays in got_bytes for the bench to inspect.
module sfrl_host (
	// Clock
	input  wire logic           i_sys_clk,
	// Requests
	output sfrl_pkg::sfrl_cmd_s o_cmd,
	output logic                o_log_rd,
	// Answers
	input  wire logic [15:0]    i_rdata,
	input  wire logic [7:0]     i_log_byte,
	input  wire logic           i_log_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got_bytes [0:254];
	int         got_count;

	initial begin
		o_cmd = '0;
		o_log_rd = 1'b0;
	end

	task automatic send(input logic wr, input logic [7:0] code, input logic [2:0] page,
			input logic [15:0] data);
		@(negedge i_sys_clk);
		o_cmd = '{wr: wr, rd: !wr, code: code, page: page, data: data};
		@(negedge i_sys_clk);
		o_cmd = '0;
	endtask

	task automatic read(input logic [7:0] code, input logic [2:0] page, output logic [15:0] d);
		send(1'b0, code, page, 16'h0000);
		@(negedge i_sys_clk);
		d = i_rdata;
	endtask

	task automatic read_record();
		got_count = 0;
		@(negedge i_sys_clk);
		o_log_rd = 1'b1;
		@(negedge i_sys_clk);
		o_log_rd = 1'b0;
		for (int n = 0; n < 400 && got_count < sfrl_pkg::LOG_BYTES; n++) begin
			@(negedge i_sys_clk);
			if (i_log_valid === 1'b1) begin
				got_bytes[got_count] = i_log_byte;
				got_count++;
			end
		end
	endtask

	task automatic clear_record();
		send(1'b1, sfrl_pkg::CMD_MODE, 3'h0, 16'h0800 | sfrl_pkg::MODE_RESET);
	endtask
endmodule // sfrl_host

// [tb/sfrl_logger_bench.sv]
// Purpose: Self-checking bench for the supply fault response logger.
// Assumes: Millisecond tick shortened to 20 cycles.
// Notes:   Supply 4 has measurement disabled so its record words read zero.
module sfrl_logger_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MS = 20;
	logic                           sys_clk = 1'b0;
	logic                           rst = 1'b1;
	sfrl_pkg::sfrl_faults_s         faults = '0;
	logic [sfrl_pkg::NSUP-1:0]      supply_on = 5'h1F;
	logic                           user_restart = 1'b0;
	logic                           nv_err = 1'b0;
	logic                           off_at_once = 1'b1;
	logic [sfrl_pkg::NSUP*16-1:0]   vout = {16'h1500, 16'h1400, 16'h1300, 16'h1200, 16'h1100};
	sfrl_pkg::sfrl_cmd_s            cmd;
	logic                           log_rd;
	logic [15:0]                    cmd_rdata;
	logic [7:0]                     log_byte;
	logic                           log_valid;
	logic [sfrl_pkg::NSUP-1:0]      supply_en;
	logic                           fault;
	logic                           alert;
	int                             err_count = 0;
	int                             tests_run = 0;
	logic [15:0]                    cfg_tab [5] = '{16'h8000, 16'h800C, 16'h0002, 16'h4100, 16'h4000};
	logic [15:0]                    retry_ms [2] = '{16'h0003, 16'h0000};

	always #2.5 sys_clk = ~sys_clk;

	sfrl_logger #(.MS_CYCLES(MS)) i_sfrl_logger (
		.i_sys_clk(sys_clk), .i_rst(rst), .i_faults(faults), .i_temp_en(6'h1F),
		.i_supply_on(supply_on), .i_off_at_once(off_at_once), .i_user_restart(user_restart),
		.i_vout(vout), .i_iout({5{16'h0200}}), .i_meas_en(5'h0F), .i_nv_err(nv_err),
		.i_cmd(cmd), .i_log_rd(log_rd), .o_cmd_rdata(cmd_rdata), .o_log_byte(log_byte),
		.o_log_valid(log_valid), .o_supply_enable_out(supply_en), .o_fault(fault),
		.o_alert(alert)
	);

	sfrl_host i_sfrl_host (
		.i_sys_clk(sys_clk), .o_cmd(cmd), .o_log_rd(log_rd), .i_rdata(cmd_rdata),
		.i_log_byte(log_byte), .i_log_valid(log_valid)
	);

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic expect_reg(input logic [7:0] code, input logic [2:0] page,
			input logic [15:0] mask, input logic [15:0] exp);
		logic [15:0] d;
		i_sfrl_host.read(code, page, d);
		check_word(d & mask, exp);
	endtask

	task automatic wait_en(input int s, input logic v, output int took);
		took = 0;
		while (supply_en[s] !== v && took < 40 * MS) begin
			@(negedge sys_clk);
			took++;
		end
		if (supply_en[s] !== v) begin
			err_count++;
			$display("unexpected at %0t: enable %h expected %h", $time, supply_en[s], v);
			tally_and_finish();
		end
	endtask

	task automatic hit(input sfrl_pkg::sfrl_faults_s f, input int settle);
		@(negedge sys_clk);
		faults = f;
		repeat (4) @(negedge sys_clk);
		faults = '0;
		repeat (settle) @(negedge sys_clk);
	endtask

	function automatic logic [15:0] rec_word(input int w);
		return {i_sfrl_host.got_bytes[2 * w + 1], i_sfrl_host.got_bytes[2 * w]};
	endfunction

	// Reads all fifteen slots from slot 0; only slot 0 is expected to hold a record.
	task automatic scan(output logic [15:0] cnt);
		logic [7:0] all;
		for (int i = 0; i < sfrl_pkg::NSLOT; i++) begin
			i_sfrl_host.read_record();
			all = 8'hFF;
			for (int b = 0; b < sfrl_pkg::LOG_BYTES; b++) begin
				all &= i_sfrl_host.got_bytes[b];
			end
			check_word(16'(i_sfrl_host.got_count), 16'h00FF); // block length
			if (i != 0) begin
				check_word({8'h00, all}, 16'h00FF); // unwritten slot
			end else begin
				cnt = rec_word(sfrl_pkg::W_COUNT);
				check_word(rec_word(sfrl_pkg::W_VOLT + 8), vout[31:16]); // newest volts
				check_word(rec_word(sfrl_pkg::W_VOLT + 32), 16'h0000); // unmeasured
			end
		end
	endtask

	initial begin
		logic [15:0] c1;
		logic [15:0] c2;
		int          took;
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		repeat (2100) @(negedge sys_clk);
		check_word({11'h000, supply_en}, 16'h001F); // all requested supplies on
		expect_reg(sfrl_pkg::CMD_FAULT_RETRY, 3'h0, 16'hFFFF, sfrl_pkg::RETRY_RESET);
		i_sfrl_host.send(1'b1, sfrl_pkg::CMD_FAULT_RESPONSE, 3'h0, 16'hFFFF);
		expect_reg(sfrl_pkg::CMD_FAULT_RESPONSE, 3'h0, 16'hFFFF, sfrl_pkg::CFG_WMASK);
		i_sfrl_host.send(1'b1, sfrl_pkg::CMD_FAULT_RESPONSE, 3'h5, 16'hC000);
		expect_reg(sfrl_pkg::CMD_FAULT_RESPONSE, 3'h5, 16'hFFFF, 16'h0000); // bad page
		expect_reg(8'h55, 3'h0, 16'hFFFF, 16'h0000); // unmapped code reads zero
		foreach (cfg_tab[p]) begin
			i_sfrl_host.send(1'b1, sfrl_pkg::CMD_FAULT_RESPONSE, 3'(p), cfg_tab[p]);
			expect_reg(sfrl_pkg::CMD_FAULT_RESPONSE, 3'(p), 16'hFFFF, cfg_tab[p]);
		end
		hit('{ov: 5'h01, default: '0}, 2 * MS);
		check_word({10'h000, alert, supply_en}, 16'h003F); // ignore code runs on
		i_sfrl_host.send(1'b1, sfrl_pkg::CMD_CLEAR_FAULTS, 3'h0, 16'h0000);
		@(negedge sys_clk);
		check_word({15'h0000, alert}, 16'h0000); // alert cleared
		nv_err = 1'b1;
		@(negedge sys_clk);
		nv_err = 1'b0;
		repeat (4) @(negedge sys_clk);
		check_word({15'h0000, alert}, 16'h0001); // storage error alert
		expect_reg(sfrl_pkg::CMD_STATUS, 3'h0, 16'hC000, 16'h8000); // comm flag only
		hit('{uv: 5'h02, default: '0}, 150);
		check_word({11'h000, supply_en}, 16'h001F); // log code runs on
		foreach (retry_ms[k]) begin
			i_sfrl_host.send(1'b1, sfrl_pkg::CMD_FAULT_RETRY, 3'h0, retry_ms[k]);
			expect_reg(sfrl_pkg::CMD_FAULT_RETRY, 3'h0, 16'hFFFF, retry_ms[k]);
			hit('{ov: 5'h04, default: '0}, 0);
			wait_en(2, 1'b0, took);
			wait_en(2, 1'b1, took);
			check_word(16'(took >= int'(retry_ms[k]) * MS - 8 && took <= (int'(retry_ms[k]) + 2) * MS),
				16'h0001); // restart delay
		end
		off_at_once = 1'b0;
		hit('{oc: 5'h08, default: '0}, 0);
		wait_en(3, 1'b0, took); // latch off
		wait_en(4, 1'b0, took); // global member follows
		check_word(16'(took > MS / 2), 16'h0001); // one supply off per tick
		repeat (5 * MS) @(negedge sys_clk);
		check_word({10'h000, fault, supply_en}, 16'h0027); // stays latched
		user_restart = 1'b1;
		@(negedge sys_clk);
		user_restart = 1'b0;
		wait_en(3, 1'b1, took);
		wait_en(4, 1'b1, took);
		check_word({15'h0000, fault}, 16'h0000); // user restart ends fault
		i_sfrl_host.send(1'b1, sfrl_pkg::CMD_CLEAR_FAULTS, 3'h0, 16'h0000);
		hit('{temp: 6'h20, default: '0}, 10);
		check_word({15'h0000, alert}, 16'h0000); // disabled sensor ignored
		hit('{temp: 6'h01, default: '0}, 10);
		check_word({15'h0000, alert}, 16'h0001); // sensor fault reaches supplies
		scan(c1);
		repeat (15) hit('{uv: 5'h02, default: '0}, 150);
		expect_reg(sfrl_pkg::CMD_STATUS, 3'h0, 16'h4000, 16'h4000); // store full
		for (int i = 0; i < sfrl_pkg::NSLOT; i++) begin
			i_sfrl_host.read_record();
			check_word(rec_word(sfrl_pkg::W_COUNT), c1 + 16'(i)); // slot order
		end
		i_sfrl_host.clear_record();
		hit('{uv: 5'h02, default: '0}, 150);
		scan(c2);
		check_word(c2, c1 + 16'h000F); // counter survives clear
		tally_and_finish();
	end
endmodule // sfrl_logger_bench
